// >>> logic/dplr_pkg.sv
// constants for the dpll output adjust and housekeeping register bank
// assumes a 100 MHz system clock and a plain register port with 16-bit words
// ****************************************************************
// Functional notes
// - Bits 15 to 9 of the output adjust register hold a seven-bit two's complement phase offset word.
// - With an 8 kHz or 2.048 MHz reference, each offset unit moves the output phase by 15 ns.
// - With a 1.544 MHz reference, each offset unit moves the output phase by 20 ns.
// - Bits 2 to 0 delay all outputs by 0 to 7 skew steps of 3.5 ns each.
// - Read-only bit 6 of the housekeeping register is high while the second reference is failed.
// - Read-only bit 5 of the housekeeping register is high while the first reference is failed.
// - Housekeeping bit 4 high selects a 65.536 MHz fast clock, low selects 32.768 MHz.
// - Only the rate select bit of the housekeeping register takes writes.
// - Read-only bit 3 shows that the phase slope limiter is restricting the input phase.
// - Bits 2 to 0 report the loop state code, with 001 and 101 reserved.
// ****************************************************************
package dplr_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;

    // register offsets
    localparam logic [15:0] OFF_ADJUST   = 16'h002D;
    localparam logic [15:0] OFF_HOUSE    = 16'h002E;
    localparam logic [15:0] OFF_IRQ_STAT = 16'h0030;
    localparam logic [15:0] OFF_IRQ_MASK = 16'h0031;

    // output adjust fields
    localparam int PHASE_LSB = 9;
    localparam int PHASE_W   = 7;
    localparam int SKEW_LSB  = 0;
    localparam int SKEW_W    = 3;
    localparam logic [6:0] RST_PHASE = 7'h00;
    localparam logic [2:0] RST_SKEW  = 3'h0;

    // housekeeping fields
    localparam int HK_SECOND_LOSS = 6;
    localparam int HK_FIRST_LOSS  = 5;
    localparam int HK_RATE        = 4;
    localparam int HK_LIMIT       = 3;
    localparam int HK_STATE_LSB   = 0;
    localparam logic RST_RATE     = 1'b0;

    // loop state codes
    localparam logic [2:0] ST_TRACK_FIRST    = 3'h0;
    localparam logic [2:0] ST_FREE_FIRST     = 3'h2;
    localparam logic [2:0] ST_REALIGN_FIRST  = 3'h3;
    localparam logic [2:0] ST_TRACK_SECOND   = 3'h4;
    localparam logic [2:0] ST_FREE_SECOND    = 3'h6;
    localparam logic [2:0] ST_REALIGN_SECOND = 3'h7;

    // reference frequency codes
    localparam logic [1:0] REF_8K    = 2'h0;
    localparam logic [1:0] REF_1544K = 2'h1;
    localparam logic [1:0] REF_2048K = 2'h2;

    // step sizes, in picoseconds as printed in ns
    localparam int STEP_FINE_PS  = 15000;
    localparam int STEP_T1_PS    = 20000;
    localparam int SKEW_STEP_PS  = 3500;
    localparam int CLK_PERIOD_PS = 10000;

    // interrupt status bits
    localparam int EV_FIRST_LOSS  = 0;
    localparam int EV_SECOND_LOSS = 1;
    localparam int EV_LIMIT       = 2;
    localparam int EV_STATE       = 3;
    localparam int EV_W           = 4;
    localparam logic [3:0] RST_EV = 4'h0;

    localparam int SHIFT_W = 24;
    localparam int SKDLY_W = 16;
endpackage

// >>> logic/dplr_regs.sv
// output adjust and housekeeping register bank of the dpll, with event interrupt
// assumes synchronous status inputs from the loop and a single-cycle strobe port
// the loop core, reference switching and the state transitions all sit outside this block
//
// The strobed register port was decided locally.
module dplr_regs
    import dplr_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      resetn,
    input  wire logic [ADDR_W-1:0]         addr,
    input  wire logic [DATA_W-1:0]         wr_data,
    input  wire logic                      wr_en,
    input  wire logic                      rd_en,
    output logic      [DATA_W-1:0]         rd_data,
    input  wire logic                      first_ref_fail,
    input  wire logic                      second_ref_fail,
    input  wire logic                      limiter_active,
    input  wire logic [2:0]                pll_state_code,
    input  wire logic [1:0]                active_ref_rate,
    output logic      [PHASE_W-1:0]        phase_offset_word,
    output logic      [SKEW_W-1:0]         output_skew_steps,
    output logic                           fast_clock_rate_select,
    output logic signed [SHIFT_W-1:0]      phase_shift_ps,
    output logic      [SKDLY_W-1:0]        skew_delay_ps,
    output logic                           irq
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    // address match, shared by read and write decode
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] off);
        hit = (a == off);
    endfunction

    // signed phase word times step size
    // rate code 11 has no defined reference and falls back to the fine step
    // the widest product, -64 coarse steps, still fits the 24-bit port
    function automatic logic signed [SHIFT_W-1:0] scale(input logic [PHASE_W-1:0] w,
                                                       input logic [1:0] rate);
        logic signed [SHIFT_W-1:0] sw;
        sw = SHIFT_W'(signed'(w));
        if (rate == REF_1544K) begin
            scale = SHIFT_W'(sw * STEP_T1_PS);
        end else begin
            scale = SHIFT_W'(sw * STEP_FINE_PS);
        end
    endfunction

    // ****************************************************************
    // control registers
    // ****************************************************************
    logic [PHASE_W-1:0] next_phase;
    logic [SKEW_W-1:0]  next_skew;
    logic               next_rate;

    // bits 8..3 are not stored, so a stray write there cannot steer anything
    // the housekeeping write touches the rate bit alone; the rest of that word is live status or reserved zeros
    always_comb begin
        next_phase = phase_offset_word;
        next_skew  = output_skew_steps;
        next_rate  = fast_clock_rate_select;
        if (wr_en && hit(addr, OFF_ADJUST)) begin
            next_phase = wr_data[PHASE_LSB +: PHASE_W];
            next_skew  = wr_data[SKEW_LSB +: SKEW_W];
        end
        if (wr_en && hit(addr, OFF_HOUSE)) begin
            next_rate = wr_data[HK_RATE];
        end
    end

    // register stage only; the adjust word resets to zero offset and zero skew
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_offset_word      <= RST_PHASE;
            output_skew_steps      <= RST_SKEW;
            fast_clock_rate_select <= RST_RATE;
        end else begin
            phase_offset_word      <= next_phase;
            output_skew_steps      <= next_skew;
            fast_clock_rate_select <= next_rate;
        end
    end

    // ****************************************************************
    // derived delay outputs
    // ****************************************************************
    logic signed [SHIFT_W-1:0] next_shift;
    logic [SKDLY_W-1:0]        next_skdly;

    // computed from the stored word so the loop sees a value one cycle after the write
    always_comb begin
        next_shift = scale(phase_offset_word, active_ref_rate);
        next_skdly = SKDLY_W'(output_skew_steps * SKEW_STEP_PS);
    end

    // the loop sees no shift and no skew until software writes the adjust word
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_shift_ps <= '0;
            skew_delay_ps  <= '0;
        end else begin
            phase_shift_ps <= next_shift;
            skew_delay_ps  <= next_skdly;
        end
    end

    // ****************************************************************
    // housekeeping view and read port
    // ****************************************************************
    logic [DATA_W-1:0] house_word;
    logic [DATA_W-1:0] next_rd;
    logic [EV_W-1:0]   ev_stat;      // interrupt status, also read back through the mux below
    logic [EV_W-1:0]   ev_mask;

    // status bits are live; reserved bits read zero whatever was written
    always_comb begin
        house_word                      = '0;
        house_word[HK_SECOND_LOSS]      = second_ref_fail;
        house_word[HK_FIRST_LOSS]       = first_ref_fail;
        house_word[HK_RATE]             = fast_clock_rate_select;
        house_word[HK_LIMIT]            = limiter_active;
        house_word[HK_STATE_LSB +: 3]   = pll_state_code;
    end

    // read data stands for one cycle only, zero otherwise
    always_comb begin
        next_rd = '0;
        if (rd_en) begin
            if (hit(addr, OFF_ADJUST)) begin
                next_rd[PHASE_LSB +: PHASE_W] = phase_offset_word;
                next_rd[SKEW_LSB +: SKEW_W]   = output_skew_steps;
            end else if (hit(addr, OFF_HOUSE)) begin
                next_rd = house_word;
            end else if (hit(addr, OFF_IRQ_STAT)) begin
                next_rd[EV_W-1:0] = ev_stat;
            end else if (hit(addr, OFF_IRQ_MASK)) begin
                next_rd[EV_W-1:0] = ev_mask;
            end
        end
    end

    // registering the mux keeps rd_data clean at the cost of one cycle of latency
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= '0;
        end else begin
            rd_data <= next_rd;
        end
    end

    // ****************************************************************
    // events and interrupt
    // ****************************************************************
    logic            prev_first;
    logic            prev_second;
    logic            prev_limit;
    logic [2:0]      prev_state;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] next_stat;
    logic [EV_W-1:0] next_mask;
    logic            next_irq;

    // set wins over a write-one clear landing in the same cycle
    // a state event fires on any code change, reserved codes included, so software sees every move
    // irq is formed from the next values so it rises in the same cycle as the status bit
    always_comb begin
        ev_set                 = '0;
        ev_set[EV_FIRST_LOSS]  = first_ref_fail && !prev_first;
        ev_set[EV_SECOND_LOSS] = second_ref_fail && !prev_second;
        ev_set[EV_LIMIT]       = limiter_active && !prev_limit;
        ev_set[EV_STATE]       = pll_state_code != prev_state;
        next_stat = ev_stat;
        if (wr_en && hit(addr, OFF_IRQ_STAT)) begin
            next_stat = ev_stat & ~wr_data[EV_W-1:0];
        end
        next_stat = next_stat | ev_set;
        next_mask = ev_mask;
        if (wr_en && hit(addr, OFF_IRQ_MASK)) begin
            next_mask = wr_data[EV_W-1:0];
        end
        next_irq = |(next_stat & next_mask);
    end

    // prev copies reset to idle so a fault present at release raises an event
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ev_stat     <= RST_EV;
            ev_mask     <= RST_EV;
            prev_first  <= 1'b0;
            prev_second <= 1'b0;
            prev_limit  <= 1'b0;
            prev_state  <= ST_TRACK_FIRST;
            irq         <= 1'b0;
        end else begin
            ev_stat     <= next_stat;
            ev_mask     <= next_mask;
            prev_first  <= first_ref_fail;
            prev_second <= second_ref_fail;
            prev_limit  <= limiter_active;
            prev_state  <= pll_state_code;
            irq         <= next_irq;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    // every check runs on the system clock and rests while reset is low
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // adjust word: a write lands at the next edge and holds until the next write
    phase_write_a: assert property (
        wr_en && addr == OFF_ADJUST
        |=> phase_offset_word == $past(wr_data[PHASE_LSB +: PHASE_W]))
        else $error("phase word not taken from its field");
    phase_hold_a: assert property (
        !(wr_en && addr == OFF_ADJUST)
        |=> $stable(phase_offset_word))
        else $error("phase word moved without a write");
    skew_write_a: assert property (
        wr_en && addr == OFF_ADJUST ##1 !wr_en [*2]
        |-> skew_delay_ps == SKDLY_W'(SKEW_STEP_PS * $past(wr_data[SKEW_LSB +: SKEW_W], 2)))
        else $error("skew delay does not follow written steps");
    skew_hold_a: assert property (
        !(wr_en && addr == OFF_ADJUST)
        |=> $stable(output_skew_steps))
        else $error("skew steps moved without a write");
    adj_read_a: assert property (
        rd_en && addr == OFF_ADJUST
        |=> rd_data == {$past(phase_offset_word), 6'h00, $past(output_skew_steps)})
        else $error("adjust read does not show the stored fields");

    // derived delays: one edge behind the stored word and the active rate
    fine_step_a: assert property (
        $stable(active_ref_rate) && active_ref_rate != REF_1544K
        |=> phase_shift_ps == SHIFT_W'(signed'($past(phase_offset_word)) * STEP_FINE_PS))
        else $error("fine phase step wrong");
    t1_step_a: assert property (
        $stable(active_ref_rate) && active_ref_rate == REF_1544K
        |=> phase_shift_ps == SHIFT_W'(signed'($past(phase_offset_word)) * STEP_T1_PS))
        else $error("t1 phase step wrong");

    // housekeeping view: live status, the rate bit, zeros elsewhere
    house_read_a: assert property (
        rd_en && addr == OFF_HOUSE
        |=> rd_data == {9'h000, $past(second_ref_fail), $past(first_ref_fail),
                        $past(fast_clock_rate_select), $past(limiter_active), $past(pll_state_code)})
        else $error("housekeeping read mismatch");
    second_loss_a: assert property (
        rd_en && addr == OFF_HOUSE && second_ref_fail
        |=> rd_data[HK_SECOND_LOSS])
        else $error("second reference loss not shown");
    first_loss_a: assert property (
        rd_en && addr == OFF_HOUSE && first_ref_fail
        |=> rd_data[HK_FIRST_LOSS])
        else $error("first reference loss not shown");
    limit_flag_a: assert property (
        rd_en && addr == OFF_HOUSE && limiter_active
        |=> rd_data[HK_LIMIT])
        else $error("limiter flag not shown");
    state_code_a: assert property (
        rd_en && addr == OFF_HOUSE
        |=> rd_data[HK_STATE_LSB +: 3] == $past(pll_state_code))
        else $error("loop state code not shown");
    rate_only_a: assert property (
        wr_en && addr == OFF_HOUSE
        |=> fast_clock_rate_select == $past(wr_data[HK_RATE]))
        else $error("rate select not written");
    ro_ignored_a: assert property (
        wr_en && addr == OFF_HOUSE ##1 rd_en && addr == OFF_HOUSE
        |=> rd_data[15:7] == 9'h000 && rd_data[3:0] == {$past(limiter_active), $past(pll_state_code)})
        else $error("read-only bits took a write");

    // read port: data stands one cycle, unmapped places read zero
    read_once_a: assert property (
        !rd_en
        |=> rd_data == 16'h0000)
        else $error("read data held beyond one cycle");
    unmapped_zero_a: assert property (
        rd_en && addr != OFF_ADJUST && addr != OFF_HOUSE && addr != OFF_IRQ_STAT && addr != OFF_IRQ_MASK
        |=> rd_data == 16'h0000)
        else $error("unmapped read returned data");

    // events: sticky status, write-one clear, level interrupt
    irq_level_a: assert property (
        ev_set[EV_FIRST_LOSS] && ev_mask[EV_FIRST_LOSS] && !(wr_en && addr == OFF_IRQ_MASK)
        |=> irq)
        else $error("masked-in loss event did not raise irq");
    first_rise_a: assert property (
        $rose(first_ref_fail) |=> ev_stat[EV_FIRST_LOSS])
        else $error("first reference loss event not latched");
    second_rise_a: assert property (
        $rose(second_ref_fail) |=> ev_stat[EV_SECOND_LOSS])
        else $error("second reference loss event not latched");
    limit_rise_a: assert property (
        $rose(limiter_active) |=> ev_stat[EV_LIMIT])
        else $error("limiter event not latched");
    stat_sticky_a: assert property (
        !(wr_en && addr == OFF_IRQ_STAT)
        |=> (ev_stat & $past(ev_stat)) == $past(ev_stat))
        else $error("event status dropped without a clear");
    stat_clear_a: assert property (
        wr_en && addr == OFF_IRQ_STAT && !(|ev_set)
        |=> !(|(ev_stat & $past(wr_data[EV_W-1:0]))))
        else $error("write-one clear did not clear");
    mask_write_a: assert property (
        wr_en && addr == OFF_IRQ_MASK
        |=> ev_mask == $past(wr_data[EV_W-1:0]))
        else $error("mask not written");

    // main scenarios worth seeing at least once
    fail_cov_c:   cover property (!first_ref_fail ##1 first_ref_fail ##1 irq);
    t1_cov_c:     cover property (active_ref_rate == REF_1544K && phase_offset_word[6]);
    clr_set_c:    cover property (wr_en && addr == OFF_IRQ_STAT && |ev_set);
    rate_cov_c:   cover property (wr_en && addr == OFF_HOUSE && wr_data[HK_RATE]);
    state_cov_c:  cover property (ev_set[EV_STATE] ##1 irq);

endmodule

// >>> verif/dplr_regs_bench.sv
// self-checking bench for the dpll adjust and housekeeping register bank
// assumes dplr_pkg compiled first; a bench model mirrors every output each cycle
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch %0t got %h exp %h", $time, g, e); end end
module dplr_regs_bench
    import dplr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                       clk, resetn, wr_en, rd_en;
    logic                       first_ref_fail, second_ref_fail, limiter_active;
    logic                       fast_clock_rate_select, irq;
    logic [15:0]                addr, wr_data, rd_data, skew_delay_ps;
    logic [2:0]                 pll_state_code, output_skew_steps;
    logic [1:0]                 active_ref_rate;
    logic [6:0]                 phase_offset_word;
    logic signed [23:0]         phase_shift_ps, m_shift;
    logic [15:0]                m_adj, m_rd, m_skd;
    logic [3:0]                 m_stat, m_mask, m_ev;
    logic [5:0]                 m_prev;
    logic                       m_rate;
    logic [31:0]                r;
    logic [15:0]                alist [5] = '{OFF_ADJUST, OFF_HOUSE, 16'h002F, OFF_IRQ_STAT, OFF_IRQ_MASK};
    int                         error_cnt = 0;
    int                         comparisons = 0;

    dplr_regs u_dplr_regs (.clk(clk), .resetn(resetn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .first_ref_fail(first_ref_fail), .second_ref_fail(second_ref_fail),
        .limiter_active(limiter_active), .pll_state_code(pll_state_code), .active_ref_rate(active_ref_rate),
        .phase_offset_word(phase_offset_word), .output_skew_steps(output_skew_steps),
        .fast_clock_rate_select(fast_clock_rate_select), .phase_shift_ps(phase_shift_ps),
        .skew_delay_ps(skew_delay_ps), .irq(irq));

    // ****************************************************************
    // reference model
    // ****************************************************************
    // old values are used before update, so reads and delays lag as the ports do
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {m_adj, m_rate, m_stat, m_mask, m_rd, m_prev, m_shift, m_skd} = '0;
        end else begin
            m_shift = 24'($signed(m_adj[15:9]) * (active_ref_rate == REF_1544K ? STEP_T1_PS : STEP_FINE_PS));
            m_skd = 16'(m_adj[2:0] * SKEW_STEP_PS);
            m_rd = 16'h0000;
            if (rd_en) begin
                case (addr)
                    OFF_ADJUST:   m_rd = m_adj;
                    OFF_HOUSE:    m_rd = {9'h000, second_ref_fail, first_ref_fail, m_rate, limiter_active,
                                          pll_state_code};
                    OFF_IRQ_STAT: m_rd = {12'h000, m_stat};
                    OFF_IRQ_MASK: m_rd = {12'h000, m_mask};
                    default:      m_rd = 16'h0000;
                endcase
            end
            m_ev = {pll_state_code != m_prev[5:3], limiter_active & ~m_prev[2],
                    second_ref_fail & ~m_prev[1], first_ref_fail & ~m_prev[0]};
            // a clear in the same cycle as a set loses to the set
            if (wr_en && addr == OFF_IRQ_STAT) m_stat = m_stat & ~wr_data[3:0];
            m_stat = m_stat | m_ev;
            if (wr_en && addr == OFF_ADJUST) m_adj = wr_data & 16'hFE07;
            if (wr_en && addr == OFF_HOUSE) m_rate = wr_data[4];
            if (wr_en && addr == OFF_IRQ_MASK) m_mask = wr_data[3:0];
            m_prev = {pll_state_code, limiter_active, second_ref_fail, first_ref_fail};
        end
    end

    // compare on the falling edge, where every registered output has settled
    always @(negedge clk) begin
        if (resetn) begin
            `CHK(rd_data, m_rd)
            `CHK(phase_offset_word, m_adj[15:9])
            `CHK(output_skew_steps, m_adj[2:0])
            `CHK(fast_clock_rate_select, m_rate)
            `CHK(phase_shift_ps, m_shift)
            `CHK(skew_delay_ps, m_skd)
            `CHK(irq, |(m_stat & m_mask))
        end
    end

    // ****************************************************************
    // stimulus
    // ****************************************************************
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_en <= 1'b1; addr <= a; wr_data <= (a == OFF_ADJUST) ? (d & 16'hFE07) : d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a);
        @(posedge clk);
        rd_en <= 1'b1; addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
    endtask

    task automatic final_report();
        if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // clock at 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // watchdog, well beyond the roughly 700 cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        final_report();
    end

    initial begin
        {resetn, wr_en, rd_en, addr, wr_data, first_ref_fail, second_ref_fail} = '0;
        {limiter_active, pll_state_code, active_ref_rate} = '0;
        void'($urandom(72));
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        foreach (alist[i]) rd(alist[i]);
        // both ends of the phase field and the top skew step, under every rate code
        for (int k = 0; k < 4; k++) begin
            active_ref_rate <= 2'(k);
            wr(OFF_ADJUST, 16'h8007);
            rd(OFF_ADJUST);
            wr(OFF_ADJUST, 16'h7FFF);
            rd(OFF_ADJUST);
        end
        wr(OFF_HOUSE, 16'hFFFF);
        rd(OFF_HOUSE);
        wr(OFF_HOUSE, 16'h0000);
        rd(OFF_HOUSE);
        // write then read with no gap, so the read shows only the rate bit moved
        @(posedge clk);
        wr_en <= 1'b1; addr <= OFF_HOUSE; wr_data <= 16'hFFFF;
        @(posedge clk);
        wr_en <= 1'b0; rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        wr(OFF_IRQ_MASK, 16'h000F);
        wr(OFF_IRQ_STAT, 16'h000F);
        // set and clear on the same edge
        @(posedge clk);
        wr_en <= 1'b1; addr <= OFF_IRQ_STAT; wr_data <= 16'h0001; first_ref_fail <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        rd(OFF_IRQ_STAT);
        wr(OFF_IRQ_MASK, 16'h0004);
        wr(OFF_IRQ_STAT, 16'h0001);
        for (int s = 0; s < 8; s++) begin
            r = $urandom;
            pll_state_code <= 3'(s); second_ref_fail <= r[0]; limiter_active <= r[1];
            rd(OFF_HOUSE);
        end
        // random traffic over every mapped place and one unmapped one
        for (int i = 0; i < 300; i++) begin
            r = $urandom;
            {first_ref_fail, second_ref_fail, limiter_active, pll_state_code, active_ref_rate} <= r[7:0];
            if (r[11]) wr(alist[r[10:8] % 5], r[31:16]);
            else rd(alist[r[10:8] % 5]);
        end
        // a second reset in mid-run must bring every register back
        @(posedge clk);
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        foreach (alist[i]) rd(alist[i]);
        repeat (3) @(posedge clk);
        final_report();
    end
endmodule
